// >>> src/aes_round_primitives.sv
// round primitive datapath: one aes round operation per request
// assumes a same-clock substitution table answers sub_query_o in the same cycle
`timescale 1ns/1ps
`default_nettype none

// Function
// - keys of 128/192/256 bits, 10/12/14 rounds
// - six round, column-mix and key-assist operations
// - inputs: 128-bit state and 128-bit round key
// - four words; byte 4j+i holds matrix byte
// - bit 7 is each byte's most significant
// - column mix with 02,03,01,01 rotated rows
// - field product: carry-less multiply, reduce modulo polynomial
// - field addition is plain bitwise xor
// - bit k is coefficient of x^k
// - word rotate: (S3,S2,S1,S0) becomes (S0,S3,S2,S1)
// - row 0 kept, rows 1-3 rotated left
module aes_round_primitives (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire aes_round_pkg::req_t req_i,
  output logic req_ready_o,
  output aes_round_pkg::sub_query_t sub_query_o,
  input wire logic [127:0] sub_result_i,
  output logic done_o,
  output logic [127:0] result_o,
  output logic [3:0] rounds_o
);
  import aes_round_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fsm_t fsm;
    logic ready;
    logic query_valid;
    logic inverse;
    op_t op;
    key_len_t key_len;
    logic [7:0] rcon;
    logic [127:0] state;
    logic [127:0] round_key;
    logic [127:0] result;
    logic [3:0] rounds;
    logic done;
  } regs_t;

  localparam regs_t REGS_RST = '{
    fsm: FSM_IDLE,
    ready: 1'b1,
    query_valid: 1'b0,
    inverse: 1'b0,
    op: encrypt_round_op,
    key_len: key_len_128,
    rcon: RCON_RST,
    state: STATE_RST,
    round_key: STATE_RST,
    result: STATE_RST,
    rounds: ROUNDS_RST,
    done: 1'b0
  };

  regs_t st_q;
  regs_t st_d;

  // ----------------------------------------------------------------
  // byte permutations
  // ----------------------------------------------------------------
  // matrix byte (i, j) lives at bits 8*(4j+i) +: 8, msb at bit 7 of the lane
  function automatic logic [7:0] get_byte(input logic [127:0] s, input int i, input int j);
    get_byte = s[8*(4*j+i) +: 8];
  endfunction : get_byte

  function automatic logic [127:0] shift_rows(input logic [127:0] s);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        // row i takes from column j+i, so row 0 stays put
        r[8*(4*j+i) +: 8] = get_byte(s, i, (j + i) % 4);
      end
    end
    shift_rows = r;
  endfunction : shift_rows

  function automatic logic [127:0] inv_shift_rows(input logic [127:0] s);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        r[8*(4*j+i) +: 8] = get_byte(s, i, (j + 4 - i) % 4);
      end
    end
    inv_shift_rows = r;
  endfunction : inv_shift_rows

  function automatic logic [31:0] rot_word(input logic [31:0] w);
    rot_word = {w[7:0], w[31:8]};
  endfunction : rot_word

  // ----------------------------------------------------------------
  // column mix, shared by forward and inverse forms
  // ----------------------------------------------------------------
  // one multiplier array serves both coefficient sets to save area
  logic [127:0] mix_in;
  logic [31:0] mix_coef;
  logic [127:0] mix_out;
  logic [7:0] mix_prod [4][4][4];

  for (genvar gi = 0; gi < 4; gi++) begin : g_row
    for (genvar gj = 0; gj < 4; gj++) begin : g_col
      for (genvar gk = 0; gk < 4; gk++) begin : g_term
        gf_byte_multiply u_mul (
          .a_i(mix_coef[8*((gk + 4 - gi) % 4) +: 8]),
          .b_i(mix_in[8*(4*gj+gk) +: 8]),
          .p_o(mix_prod[gi][gj][gk])
        );
      end
    end
  end

  always_comb begin
    mix_out = '0;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        // each column on its own; terms join by xor
        mix_out[8*(4*j+i) +: 8] = mix_prod[i][j][0] ^ mix_prod[i][j][1]
                                ^ mix_prod[i][j][2] ^ mix_prod[i][j][3];
      end
    end
  end

  // ----------------------------------------------------------------
  // operation result
  // ----------------------------------------------------------------
  logic [127:0] op_result;
  logic [31:0] assist_lo;
  logic [31:0] assist_hi;

  // mix operand chosen apart from the result mux, so no path folds back on itself
  always_comb begin
    mix_coef = MIX_FWD_COEF;
    mix_in = shift_rows(sub_result_i);
    unique case (st_q.op)
      decrypt_round_op: begin
        // equivalent inverse cipher: inverse mix before the key add
        mix_coef = MIX_INV_COEF;
        mix_in = inv_shift_rows(sub_result_i);
      end
      inverse_column_mix_op: begin
        mix_coef = MIX_INV_COEF;
        mix_in = st_q.state;
      end
      default: begin
        mix_coef = MIX_FWD_COEF;
      end
    endcase
  end

  always_comb begin
    assist_lo = sub_result_i[63:32];
    assist_hi = sub_result_i[127:96];
    op_result = STATE_RST;
    unique case (st_q.op)
      encrypt_round_op: begin
        op_result = mix_out ^ st_q.round_key;
      end
      encrypt_final_round_op: begin
        op_result = shift_rows(sub_result_i) ^ st_q.round_key;
      end
      decrypt_round_op: begin
        op_result = mix_out ^ st_q.round_key;
      end
      decrypt_final_round_op: begin
        op_result = inv_shift_rows(sub_result_i) ^ st_q.round_key;
      end
      inverse_column_mix_op: begin
        op_result = mix_out;
      end
      round_key_assist_op: begin
        // substituted words 1 and 3, each also rotated and xored with rcon
        op_result = {rot_word(assist_hi) ^ {24'h00_0000, st_q.rcon}, assist_hi,
                     rot_word(assist_lo) ^ {24'h00_0000, st_q.rcon}, assist_lo};
      end
      default: begin
        op_result = STATE_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // request sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    unique case (st_q.fsm)
      FSM_IDLE: begin
        if (req_valid_i) begin
          st_d.fsm = FSM_LOOKUP;
          st_d.ready = 1'b0;
          st_d.query_valid = 1'b1;
          st_d.inverse = (req_i.op == decrypt_round_op)
                       || (req_i.op == decrypt_final_round_op);
          st_d.op = req_i.op;
          st_d.key_len = req_i.key_len;
          st_d.rcon = req_i.rcon;
          st_d.state = req_i.state;
          st_d.round_key = req_i.round_key;
        end
      end
      FSM_LOOKUP: begin
        st_d.fsm = FSM_IDLE;
        st_d.ready = 1'b1;
        st_d.query_valid = 1'b0;
        st_d.result = op_result;
        st_d.done = 1'b1;
        // round count follows the key length; unused code 3 reports zero
        unique case (st_q.key_len)
          key_len_128: st_d.rounds = ROUNDS_KEY_128;
          key_len_192: st_d.rounds = ROUNDS_KEY_192;
          key_len_256: st_d.rounds = ROUNDS_KEY_256;
          default: st_d.rounds = ROUNDS_RST;
        endcase
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= REGS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign req_ready_o = st_q.ready;
  assign sub_query_o = '{valid: st_q.query_valid, inverse: st_q.inverse, data: st_q.state};
  assign done_o = st_q.done;
  assign result_o = st_q.result;
  assign rounds_o = st_q.rounds;

endmodule : aes_round_primitives
`default_nettype wire

// >>> include/aes_round_pkg.sv
// package for the aes round primitive datapath: op codes, carriers, constants
// assumes a single 100 MHz clock domain and a same-clock byte substitution table
`default_nettype none
package aes_round_pkg;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    encrypt_round_op       = 3'h0,
    encrypt_final_round_op = 3'h1,
    decrypt_round_op       = 3'h2,
    decrypt_final_round_op = 3'h3,
    inverse_column_mix_op  = 3'h4,
    round_key_assist_op    = 3'h5
  } op_t;

  // ----------------------------------------------------------------
  // cipher key lengths and their round counts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    key_len_128 = 2'h0,
    key_len_192 = 2'h1,
    key_len_256 = 2'h2
  } key_len_t;

  localparam logic [3:0] ROUNDS_KEY_128 = 4'ha;
  localparam logic [3:0] ROUNDS_KEY_192 = 4'hc;
  localparam logic [3:0] ROUNDS_KEY_256 = 4'he;

  // ----------------------------------------------------------------
  // field arithmetic
  // ----------------------------------------------------------------
  // x^8+x^4+x^3+x+1, held at the width of the raw carry-less product
  localparam logic [14:0] GF_REDUCE_POLY = 15'h011b;
  // coefficients by distance (k - i) mod 4, distance 0 in the low byte
  localparam logic [31:0] MIX_FWD_COEF = 32'h0101_0302;
  localparam logic [31:0] MIX_INV_COEF = 32'h090d_0b0e;

  // ----------------------------------------------------------------
  // state layout and reset values
  // ----------------------------------------------------------------
  localparam int STATE_W = 128;
  localparam int WORD_W = 32;
  localparam int BYTE_W = 8;
  localparam logic [127:0] STATE_RST = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
  localparam logic [7:0] RCON_RST = 8'h00;
  localparam logic [3:0] ROUNDS_RST = 4'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    op_t op;
    key_len_t key_len;
    logic [7:0] rcon;
    logic [127:0] state;
    logic [127:0] round_key;
  } req_t;

  typedef struct packed {
    logic valid;
    logic inverse;
    logic [127:0] data;
  } sub_query_t;

  typedef enum logic {
    FSM_IDLE = 1'b0,
    FSM_LOOKUP = 1'b1
  } fsm_t;

endpackage : aes_round_pkg
`default_nettype wire

// >>> src/gf_byte_multiply.sv
// one byte product in the 256-element field
// assumes purely combinational use inside the round datapath
`timescale 1ns/1ps
`default_nettype none

module gf_byte_multiply (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  output logic [7:0] p_o
);
  import aes_round_pkg::*;

  logic [14:0] prod;

  always_comb begin
    prod = 15'h0000;
    // bit k stands for x^k; partial products add by xor, no carries
    for (int k = 0; k < 8; k++) begin
      if (b_i[k]) begin
        prod = prod ^ ({7'h00, a_i} << k);
      end
    end
    // fold from the top so each step clears the highest set bit
    for (int k = 14; k >= 8; k--) begin
      if (prod[k]) begin
        prod = prod ^ (GF_REDUCE_POLY << (k - 8));
      end
    end
    p_o = prod[7:0];
  end

endmodule : gf_byte_multiply
`default_nettype wire

// >>> sim/sub_table_model.sv
// stand-in for the byte substitution tables: two simple invertible byte maps
// assumes the datapath's same-clock lookup port; the real tables are not modelled
`timescale 1ns/1ps
`default_nettype none
module sub_table_model (
  input wire logic sys_clk_i,
  input wire aes_round_pkg::sub_query_t sub_query_i,
  output logic [127:0] sub_result_o
);
  import aes_round_pkg::*;
  logic [7:0] junk_q = 8'h5a;
  always @(posedge sys_clk_i) junk_q <= junk_q + 8'h01;
  // outside a query the lines carry a moving pattern, never the last answer
  always_comb sub_result_o = !sub_query_i.valid ? {16{junk_q}} :
      sub_query_i.data ^ {16{sub_query_i.inverse ? 8'h05 : 8'h63}};
endmodule : sub_table_model
`default_nettype wire

// >>> sim/aes_round_primitives_props.sv
// port-level checks of the round datapath's handshake and result timing
// assumes only the top module's ports are visible
`timescale 1ns/1ps
`default_nettype none
module aes_round_primitives_props (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire aes_round_pkg::req_t req_i,
  input wire logic req_ready_o,
  input wire aes_round_pkg::sub_query_t sub_query_o,
  input wire logic [127:0] sub_result_i,
  input wire logic done_o,
  input wire logic [127:0] result_o,
  input wire logic [3:0] rounds_o
);
  import aes_round_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire take = req_valid_i && req_ready_o;
  a_done_latency: assert property (take |-> ##2 done_o) else $error("done late");
  a_ready_gap: assert property (take |=> !req_ready_o ##1 req_ready_o)
    else $error("ready gap wrong");
  a_query_data: assert property (take |=> sub_query_o.valid &&
    sub_query_o.data == $past(req_i.state)) else $error("query data wrong");
  a_query_inverse: assert property (take && req_i.op < 3'h4 |=>
    sub_query_o.inverse == $past(req_i.op[1])) else $error("table choice wrong");
  a_rounds_map: assert property (take |-> ##2 rounds_o ==
    ($past(req_i.key_len, 2) == key_len_128 ? 4'ha : $past(req_i.key_len, 2) ==
    key_len_192 ? 4'hc : $past(req_i.key_len, 2) == key_len_256 ? 4'he : 4'h0))
    else $error("round count wrong");
  a_done_single: assert property (done_o |=> !done_o) else $error("done too long");
  a_done_cause: assert property (done_o |-> $past(take, 2)) else $error("stray done");
  a_result_hold: assert property (!done_o |-> $stable(result_o))
    else $error("result moved");
  a_bad_op_zero: assert property (take && req_i.op > 3'h5 |-> ##2 result_o == '0)
    else $error("bad op result");
endmodule : aes_round_primitives_props
bind aes_round_primitives aes_round_primitives_props aes_round_primitives_props_inst (
  .sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i),
  .req_valid_i(req_valid_i),
  .req_i(req_i),
  .req_ready_o(req_ready_o),
  .sub_query_o(sub_query_o),
  .sub_result_i(sub_result_i),
  .done_o(done_o),
  .result_o(result_o),
  .rounds_o(rounds_o)
);
`default_nettype wire

// >>> sim/aes_round_primitives_test.sv
// self-checking bench for the round datapath with a substitution stand-in
// assumes sub_table_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module aes_round_primitives_test;
  import aes_round_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  req_t req_i = '0;
  logic req_ready_o, done_o;
  sub_query_t sub_query_o;
  logic [127:0] sub_result_i, result_o;
  logic [3:0] rounds_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  aes_round_primitives aes_round_primitives_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .sub_query_o(sub_query_o), .sub_result_i(sub_result_i), .done_o(done_o),
    .result_o(result_o), .rounds_o(rounds_o));
  sub_table_model sub_table_model_inst (.sys_clk_i(sys_clk_i), .sub_query_i(sub_query_o),
    .sub_result_o(sub_result_i));
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int k = 0; k < 8; k++) begin
      if (b[k]) p ^= a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
    end
    return p;
  endfunction : gm
  function automatic logic [127:0] mix(input logic [127:0] s, input logic [31:0] c);
    logic [127:0] o;
    o = '0;
    for (int j = 0; j < 4; j++) for (int i = 0; i < 4; i++) for (int k = 0; k < 4; k++)
      o[32*j+8*i+:8] ^= gm(c[8*((k-i+4)%4)+:8], s[32*j+8*k+:8]);
    return o;
  endfunction : mix
  function automatic logic [127:0] shift(input logic [127:0] s, input int d);
    logic [127:0] o;
    for (int j = 0; j < 4; j++) for (int i = 0; i < 4; i++)
      o[32*j+8*i+:8] = s[32*((j+d*i)%4)+8*i+:8];
    return o;
  endfunction : shift
  function automatic logic [31:0] rw(input logic [31:0] w, input logic [7:0] rc);
    return {w[7:0], w[31:8]} ^ {24'h00_0000, rc};
  endfunction : rw
  function automatic logic [127:0] exp_res(input op_t op, input logic [127:0] st, k);
    logic [127:0] sb;
    sb = st ^ {16{op inside {decrypt_round_op, decrypt_final_round_op} ? 8'h05 : 8'h63}};
    case (op)
      encrypt_round_op: return mix(shift(sb, 1), MIX_FWD_COEF) ^ k;
      encrypt_final_round_op: return shift(sb, 1) ^ k;
      decrypt_round_op: return mix(shift(sb, 3), MIX_INV_COEF) ^ k;
      decrypt_final_round_op: return shift(sb, 3) ^ k;
      inverse_column_mix_op: return mix(st, MIX_INV_COEF);
      round_key_assist_op: return {rw(sb[127:96], 8'h36), sb[127:96],
        rw(sb[63:32], 8'h36), sb[63:32]};
      default: return '0;
    endcase
  endfunction : exp_res
  task automatic run(input op_t op, input key_len_t kl, input logic [127:0] st, k);
    @(posedge sys_clk_i);
    req_i <= '{op, kl, 8'h36, st, k};
    req_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    // look at done only once the taking edge's updates have landed
    #1;
    for (int n = 0; n < 4 && done_o !== 1'b1; n++) begin
      @(posedge sys_clk_i);
      #1;
    end
    `CHK(done_o, 1'b1)
  endtask : run
  // every op code, every key length, with a lopsided state so row moves show
  task automatic t_ops();
    logic [3:0] rtab [4] = '{4'ha, 4'hc, 4'he, 4'h0};
    logic [127:0] st, k;
    st = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    k = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    for (int n = 0; n < 8; n++) begin
      run(op_t'(3'(n)), key_len_t'(2'(n % 4)), st, k);
      `CHK(result_o, exp_res(op_t'(3'(n)), st, k))
      `CHK(rounds_o, rtab[n%4])
    end
  endtask : t_ops
  // printed column-mix vector, byte-reflected before loading
  task automatic t_vector();
    run(inverse_column_mix_op, key_len_128, 128'h4c26_0628_7ad3_f848_9a19_cbe0_e581_6604,
      '0);
    `CHK(result_o, 128'he598_271e_f111_41b8_ae52_b4e0_305d_bfd4)
  endtask : t_vector
  // mid-run reset: outputs fall back to reset values, then a request works again
  task automatic t_reset();
    logic [127:0] st;
    st = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    `CHK({req_ready_o, done_o}, 2'h2)
    `CHK(sub_query_o, '0)
    `CHK(result_o, STATE_RST)
    `CHK(rounds_o, ROUNDS_RST)
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    run(decrypt_round_op, key_len_192, st, ~st);
    `CHK(result_o, exp_res(decrypt_round_op, st, ~st))
    `CHK(rounds_o, ROUNDS_KEY_192)
  endtask : t_reset
  task automatic report_and_stop();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_ops();
    t_vector();
    t_reset();
    report_and_stop();
  end
endmodule : aes_round_primitives_test
`default_nettype wire
